/* core/pvr_top.sv */
// Vendor management registers and MMD portal behind an MDC/MDIO slave
// Notes on behaviour
// (RQ1) Crossover disable bit 6 set turns off automatic pair swap detection.
// (RQ2) With detection off, bit 7 forces MDI when one, MDI-X when zero.
// (RQ3) In power-down, clocks gate when bit 11 is zero, run when one.
// (RQ4) In power-down, PLL runs when bit 10 is zero, stops when one.
// (RQ5) Bit 7 enables static IO test; bit 6 picks supply or ground level.
// (RQ6) Loopback register bit 3 enables external loopback, clear is normal.
// (RQ7) Control bit 14 inverts the interrupt output polarity.
// (RQ8) Bit 9 enables the jabber counter, set after reset.
// (RQ9) Bit 8 enables the SQE test, set after reset.
// (RQ10) Read-only bits 6/5/4 show speed 1000/100/10, bit 3 duplex.
// (RQ11) Read-only bit 2 shows gigabit master when one, slave when zero.
// (RQ12) Bit 1 written one resets transceiver logic, clears on read.
// (RQ13) Bit 0 sets on link check failure and clears on read.
// (RQ14) Portal addresses 32 devices of 65536 words; a small subset exists.
// (RQ15) Indirect registers are reached only through two portal registers.
// (RQ16) Address function plus device, then register address in data port.
// (RQ17) Data function then makes data port accesses hit the register.
// (RQ18) Post-increment function advances the address after each access.
// (RQ19) Function code C002h post-increments on writes.
// (RQ20) Control bits 15:14 hold function, bits 4:0 the device address.
// (RQ21) Reserved bits ignore writes and read as zero.
`timescale 1ns/1ps
module pvr_top (
  ref_clk,
  rst,
  mdc,
  mdio_i,
  mdio_o,
  mdio_oe,
  phy_addr,
  spd_active,
  irq_active,
  link_check_fail,
  speed_1000,
  speed_100,
  speed_10,
  duplex_full,
  gig_master,
  auto_xover_en,
  mdi_straight,
  int_clk_gate,
  pll_off,
  io_test_en,
  io_test_high,
  ext_loopback,
  irq_out,
  jabber_en,
  sqe_test_en,
  xcvr_soft_reset
);
  input wire logic ref_clk;
  input wire logic rst;
  input wire logic mdc;
  input wire logic mdio_i;
  output logic mdio_o;
  output logic mdio_oe;
  input wire logic [4:0] phy_addr;
  input wire logic spd_active;
  input wire logic irq_active;
  input wire logic link_check_fail;
  input wire logic speed_1000;
  input wire logic speed_100;
  input wire logic speed_10;
  input wire logic duplex_full;
  input wire logic gig_master;
  output logic auto_xover_en;
  output logic mdi_straight;
  output logic int_clk_gate;
  output logic pll_off;
  output logic io_test_en;
  output logic io_test_high;
  output logic ext_loopback;
  output logic irq_out;
  output logic jabber_en;
  output logic sqe_test_en;
  output logic xcvr_soft_reset;

  import pvr_pkg::*;

  // Pin synchronisers; only stage two and later are read by logic
  logic mdc_s1_q, mdc_s2_q, mdc_s3_q;
  logic mdio_s1_q, mdio_s2_q;
  logic [4:0] pad_s1_q, pad_s2_q;
  logic mdc_rise;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mdc_s1_q <= 1'b0;
      mdc_s2_q <= 1'b0;
      mdc_s3_q <= 1'b0;
      mdio_s1_q <= 1'b1;
      mdio_s2_q <= 1'b1;
      pad_s1_q <= 5'h00;
      pad_s2_q <= 5'h00;
    end else begin
      mdc_s1_q <= mdc;
      mdc_s2_q <= mdc_s1_q;
      mdc_s3_q <= mdc_s2_q;
      mdio_s1_q <= mdio_i;
      mdio_s2_q <= mdio_s1_q;
      pad_s1_q <= phy_addr;
      pad_s2_q <= pad_s1_q;
    end
  end

  assign mdc_rise = mdc_s2_q & ~mdc_s3_q;

  // Frame receiver state
  pvr_state_e state_q;
  logic [5:0] ones_q;
  logic [3:0] cnt_q;
  logic [11:0] hdr_q;
  logic [15:0] shift_q;
  logic [11:0] hdr_d;
  logic frame_read_q, frame_write_q;
  logic [4:0] reg_q;
  logic rd_pulse_q, wr_pulse_q;
  logic [15:0] wr_data_q;
  logic [15:0] rd_word;
  logic [15:0] rd_shift_q;
  logic mdio_o_q, mdio_oe_q;

  assign hdr_d = {hdr_q[10:0], mdio_s2_q};

  // Preamble hunt, start, header, turnaround and data phases
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= PVR_ST_PRE;
      ones_q <= 6'h00;
      cnt_q <= 4'h0;
      hdr_q <= 12'h000;
      shift_q <= 16'h0000;
      frame_read_q <= 1'b0;
      frame_write_q <= 1'b0;
      reg_q <= 5'h00;
    end else if (mdc_rise) begin
      case (state_q)
        PVR_ST_PRE: begin
          if (mdio_s2_q) begin
            if (ones_q != PVR_PRE_LEN) ones_q <= ones_q + 6'h01;
          end else begin
            if (ones_q == PVR_PRE_LEN) state_q <= PVR_ST_START;
            ones_q <= 6'h00;
          end
        end
        PVR_ST_START: begin
          state_q <= mdio_s2_q ? PVR_ST_HDR : PVR_ST_PRE;
          cnt_q <= 4'h0;
        end
        PVR_ST_HDR: begin
          hdr_q <= hdr_d;
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == PVR_HDR_LAST) begin
            cnt_q <= 4'h0;
            reg_q <= hdr_d[4:0];
            frame_read_q <= (hdr_d[11:10] == PVR_OP_READ) &&
                            (hdr_d[9:5] == pad_s2_q);
            frame_write_q <= (hdr_d[11:10] == PVR_OP_WRITE) &&
                             (hdr_d[9:5] == pad_s2_q);
            state_q <= PVR_ST_TA;
          end
        end
        PVR_ST_TA: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q != 4'h0) begin
            cnt_q <= 4'h0;
            state_q <= PVR_ST_DATA;
          end
        end
        PVR_ST_DATA: begin
          shift_q <= {shift_q[14:0], mdio_s2_q};
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == PVR_DATA_LAST) begin
            cnt_q <= 4'h0;
            state_q <= PVR_ST_PRE;
          end
        end
        default: state_q <= PVR_ST_PRE;
      endcase
    end
  end

  // One-cycle strobes: read snapshot at turnaround, write at last bit
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_pulse_q <= 1'b0;
      wr_pulse_q <= 1'b0;
      wr_data_q <= 16'h0000;
    end else begin
      rd_pulse_q <= mdc_rise && state_q == PVR_ST_TA && cnt_q == 4'h0 &&
                    frame_read_q;
      wr_pulse_q <= mdc_rise && state_q == PVR_ST_DATA &&
                    cnt_q == PVR_DATA_LAST && frame_write_q;
      if (mdc_rise && state_q == PVR_ST_DATA && cnt_q == PVR_DATA_LAST) begin
        wr_data_q <= {shift_q[14:0], mdio_s2_q};
      end
    end
  end

  // Read data driver: zero in the second turnaround bit, then MSB first
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mdio_o_q <= 1'b1;
      mdio_oe_q <= 1'b0;
      rd_shift_q <= 16'h0000;
    end else if (rd_pulse_q) begin
      rd_shift_q <= rd_word;
    end else if (mdc_rise && frame_read_q) begin
      if (state_q == PVR_ST_TA && cnt_q == 4'h0) begin
        mdio_oe_q <= 1'b1;
        mdio_o_q <= 1'b0;
      end else if (state_q == PVR_ST_TA ||
                   (state_q == PVR_ST_DATA && cnt_q != PVR_DATA_LAST)) begin
        mdio_o_q <= rd_shift_q[15];
        rd_shift_q <= {rd_shift_q[14:0], 1'b0};
      end else if (state_q == PVR_ST_DATA) begin
        mdio_oe_q <= 1'b0;
        mdio_o_q <= 1'b1;
      end
    end
  end

  // Writable register bits
  logic xover_dis_q, straight_q;
  logic gate_ovr_q, pll_dis_q, io_test_q, io_level_q;
  logic lpbk_q, int_inv_q, jabber_q, sqe_q;
  logic swrst_q, lnkfail_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      xover_dis_q <= 1'b0;
      straight_q <= 1'b0;
      gate_ovr_q <= 1'b0;
      pll_dis_q <= 1'b0;
      io_test_q <= 1'b0;
      io_level_q <= 1'b0;
      lpbk_q <= 1'b0;
      int_inv_q <= 1'b0;
      jabber_q <= PVR_RST_JABBER;
      sqe_q <= PVR_RST_SQE;
    end else if (wr_pulse_q) begin
      // Only defined bits are stored; reserved bits are dropped
      case (reg_q)
        PVR_REG_XOVER: begin
          xover_dis_q <= wr_data_q[PVR_XOVER_DISABLE_BIT]; // see RQ1
          straight_q <= wr_data_q[PVR_XOVER_STRAIGHT_BIT]; // see RQ2
        end
        PVR_REG_SPD: begin
          gate_ovr_q <= wr_data_q[PVR_SPD_GATE_OVR_BIT]; // see RQ3
          pll_dis_q <= wr_data_q[PVR_SPD_PLL_DIS_BIT]; // see RQ4
          io_test_q <= wr_data_q[PVR_SPD_IO_TEST_BIT]; // see RQ5
          io_level_q <= wr_data_q[PVR_SPD_IO_LEVEL_BIT]; // see RQ5
        end
        PVR_REG_LPBK: lpbk_q <= wr_data_q[PVR_LPBK_EN_BIT]; // see RQ6
        PVR_REG_CTLSTAT: begin
          int_inv_q <= wr_data_q[PVR_CS_INT_INV_BIT]; // see RQ7
          jabber_q <= wr_data_q[PVR_CS_JABBER_BIT]; // see RQ8
          sqe_q <= wr_data_q[PVR_CS_SQE_BIT]; // see RQ9
        end
        default: ;
      endcase
    end
  end

  // Soft reset: write one sets, read clears; a write of zero does nothing
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      swrst_q <= 1'b0;
    end else if (wr_pulse_q && reg_q == PVR_REG_CTLSTAT &&
                 wr_data_q[PVR_CS_SWRST_BIT]) begin
      swrst_q <= 1'b1; // see RQ12
    end else if (rd_pulse_q && reg_q == PVR_REG_CTLSTAT) begin
      swrst_q <= 1'b0; // see RQ12
    end
  end

  // Link check failure flag; a new failure wins over the read clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lnkfail_q <= 1'b0;
    end else if (link_check_fail) begin
      lnkfail_q <= 1'b1; // see RQ13
    end else if (rd_pulse_q && reg_q == PVR_REG_CTLSTAT) begin
      lnkfail_q <= 1'b0; // see RQ13
    end
  end

  // MMD portal: function, device address and register address
  logic [1:0] mmd_func_q;
  logic [4:0] mmd_devad_q;
  logic [15:0] mmd_addr_q;
  logic mmd_hit;
  logic mmd_data_wr, mmd_data_rd;
  pvr_mem_if mem_bus ();

  // Only devices 0..3, registers 0..15 are backed by storage
  assign mmd_hit = mmd_devad_q[4:PVR_MEM_DEV_BITS] == '0 &&
                   mmd_addr_q[15:PVR_MEM_REG_BITS] == '0; // see RQ14
  assign mmd_data_wr = wr_pulse_q && reg_q == PVR_REG_MMD_DATA;
  assign mmd_data_rd = rd_pulse_q && reg_q == PVR_REG_MMD_DATA;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mmd_func_q <= PVR_FN_ADDR;
      mmd_devad_q <= 5'h00;
      mmd_addr_q <= 16'h0000;
    end else if (wr_pulse_q && reg_q == PVR_REG_MMD_CTL) begin
      mmd_func_q <= wr_data_q[PVR_MMD_FUNC_HI:PVR_MMD_FUNC_LO]; // see RQ20
      mmd_devad_q <= wr_data_q[PVR_MMD_DEVAD_HI:0]; // see RQ16
    end else if (mmd_data_wr) begin
      if (mmd_func_q == PVR_FN_ADDR) begin
        mmd_addr_q <= wr_data_q; // see RQ16
      end else if (mmd_func_q[1]) begin
        mmd_addr_q <= mmd_addr_q + 16'h0001; // see RQ18, see RQ19
      end
    end else if (mmd_data_rd && mmd_func_q == PVR_FN_INC_RW) begin
      mmd_addr_q <= mmd_addr_q + 16'h0001; // see RQ18
    end
  end

  // Data writes reach storage only through the portal
  assign mem_bus.we = mmd_data_wr && mmd_func_q != PVR_FN_ADDR &&
                      mmd_hit; // see RQ15, see RQ17
  assign mem_bus.addr = {mmd_devad_q[PVR_MEM_DEV_BITS-1:0],
                         mmd_addr_q[PVR_MEM_REG_BITS-1:0]};
  assign mem_bus.wdata = wr_data_q;

  pvr_mmd_mem u_mem (
    .ref_clk (ref_clk),
    .bus (mem_bus.mem)
  );

  // Read multiplexer; reserved and unmapped bits read as zero
  always_comb begin
    rd_word = 16'h0000; // see RQ21
    case (reg_q)
      PVR_REG_MMD_CTL: begin
        rd_word[PVR_MMD_FUNC_HI:PVR_MMD_FUNC_LO] = mmd_func_q;
        rd_word[PVR_MMD_DEVAD_HI:0] = mmd_devad_q;
      end
      PVR_REG_MMD_DATA: begin
        if (mmd_func_q == PVR_FN_ADDR) rd_word = mmd_addr_q;
        else if (mmd_hit) rd_word = mem_bus.rdata; // see RQ17
      end
      PVR_REG_XOVER: begin
        rd_word[PVR_XOVER_DISABLE_BIT] = xover_dis_q;
        rd_word[PVR_XOVER_STRAIGHT_BIT] = straight_q;
      end
      PVR_REG_SPD: begin
        rd_word[PVR_SPD_GATE_OVR_BIT] = gate_ovr_q;
        rd_word[PVR_SPD_PLL_DIS_BIT] = pll_dis_q;
        rd_word[PVR_SPD_IO_TEST_BIT] = io_test_q;
        rd_word[PVR_SPD_IO_LEVEL_BIT] = io_level_q;
      end
      PVR_REG_LPBK: rd_word[PVR_LPBK_EN_BIT] = lpbk_q;
      PVR_REG_CTLSTAT: begin
        rd_word[PVR_CS_INT_INV_BIT] = int_inv_q;
        rd_word[PVR_CS_JABBER_BIT] = jabber_q;
        rd_word[PVR_CS_SQE_BIT] = sqe_q;
        rd_word[PVR_CS_SPD1000_BIT] = speed_1000; // see RQ10
        rd_word[PVR_CS_SPD100_BIT] = speed_100; // see RQ10
        rd_word[PVR_CS_SPD10_BIT] = speed_10; // see RQ10
        rd_word[PVR_CS_DUPLEX_BIT] = duplex_full; // see RQ10
        rd_word[PVR_CS_MASTER_BIT] = gig_master; // see RQ11
        rd_word[PVR_CS_SWRST_BIT] = swrst_q;
        rd_word[PVR_CS_LNKFAIL_BIT] = lnkfail_q;
      end
      default: ;
    endcase
  end

  // Registered control outputs to the transceiver core
  logic auto_xover_q, mdi_straight_q, clk_gate_q, pll_off_q;
  logic io_test_out_q, io_high_q, lpbk_out_q, irq_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      auto_xover_q <= 1'b1;
      mdi_straight_q <= 1'b0;
      clk_gate_q <= 1'b0;
      pll_off_q <= 1'b0;
      io_test_out_q <= 1'b0;
      io_high_q <= 1'b0;
      lpbk_out_q <= 1'b0;
      irq_q <= 1'b1;
    end else begin
      auto_xover_q <= ~xover_dis_q; // see RQ1
      mdi_straight_q <= xover_dis_q & straight_q; // see RQ2
      clk_gate_q <= spd_active & ~gate_ovr_q; // see RQ3
      pll_off_q <= spd_active & pll_dis_q; // see RQ4
      io_test_out_q <= io_test_q; // see RQ5
      io_high_q <= io_test_q & io_level_q; // see RQ5
      lpbk_out_q <= lpbk_q; // see RQ6
      irq_q <= int_inv_q ? irq_active : ~irq_active; // see RQ7
    end
  end

  assign mdio_o = mdio_o_q;
  assign mdio_oe = mdio_oe_q;
  assign auto_xover_en = auto_xover_q;
  assign mdi_straight = mdi_straight_q;
  assign int_clk_gate = clk_gate_q;
  assign pll_off = pll_off_q;
  assign io_test_en = io_test_out_q;
  assign io_test_high = io_high_q;
  assign ext_loopback = lpbk_out_q;
  assign irq_out = irq_q;
  assign jabber_en = jabber_q; // see RQ8
  assign sqe_test_en = sqe_q; // see RQ9
  assign xcvr_soft_reset = swrst_q;
endmodule // pvr_top

/* core/pvr_pkg.sv */
// Constants and types for the vendor register bank and MMD portal
package pvr_pkg;

  // Management register numbers
  localparam logic [4:0] PVR_REG_MMD_CTL = 5'h0D;
  localparam logic [4:0] PVR_REG_MMD_DATA = 5'h0E;
  localparam logic [4:0] PVR_REG_XOVER = 5'h1C;
  localparam logic [4:0] PVR_REG_SPD = 5'h1D;
  localparam logic [4:0] PVR_REG_LPBK = 5'h1E;
  localparam logic [4:0] PVR_REG_CTLSTAT = 5'h1F;

  // Crossover control fields
  localparam int PVR_XOVER_STRAIGHT_BIT = 7;
  localparam int PVR_XOVER_DISABLE_BIT = 6;

  // Software power-down control fields
  localparam int PVR_SPD_GATE_OVR_BIT = 11;
  localparam int PVR_SPD_PLL_DIS_BIT = 10;
  localparam int PVR_SPD_IO_TEST_BIT = 7;
  localparam int PVR_SPD_IO_LEVEL_BIT = 6;

  // External loopback field
  localparam int PVR_LPBK_EN_BIT = 3;

  // Control/status fields
  localparam int PVR_CS_INT_INV_BIT = 14;
  localparam int PVR_CS_JABBER_BIT = 9;
  localparam int PVR_CS_SQE_BIT = 8;
  localparam int PVR_CS_SPD1000_BIT = 6;
  localparam int PVR_CS_SPD100_BIT = 5;
  localparam int PVR_CS_SPD10_BIT = 4;
  localparam int PVR_CS_DUPLEX_BIT = 3;
  localparam int PVR_CS_MASTER_BIT = 2;
  localparam int PVR_CS_SWRST_BIT = 1;
  localparam int PVR_CS_LNKFAIL_BIT = 0;

  // Reset values of the writable bits
  localparam logic PVR_RST_JABBER = 1'b1;
  localparam logic PVR_RST_SQE = 1'b1;

  // MMD access control layout and function codes
  localparam int PVR_MMD_FUNC_HI = 15;
  localparam int PVR_MMD_FUNC_LO = 14;
  localparam int PVR_MMD_DEVAD_HI = 4;
  localparam logic [1:0] PVR_FN_ADDR = 2'h0;
  localparam logic [1:0] PVR_FN_DATA = 2'h1;
  localparam logic [1:0] PVR_FN_INC_RW = 2'h2;
  localparam logic [1:0] PVR_FN_INC_WR = 2'h3;

  // Implemented MMD subset: devices 0..3, registers 0..15 of each
  localparam int PVR_MEM_DEV_BITS = 2;
  localparam int PVR_MEM_REG_BITS = 4;
  localparam int PVR_MEM_AW = PVR_MEM_DEV_BITS + PVR_MEM_REG_BITS;
  localparam int PVR_MEM_DEPTH = 64;

  // Serial management frame
  localparam logic [5:0] PVR_PRE_LEN = 6'h20;
  localparam logic [1:0] PVR_OP_WRITE = 2'h1;
  localparam logic [1:0] PVR_OP_READ = 2'h2;
  localparam logic [3:0] PVR_HDR_LAST = 4'hB;
  localparam logic [3:0] PVR_DATA_LAST = 4'hF;

  typedef enum logic [2:0] {
    PVR_ST_PRE,
    PVR_ST_START,
    PVR_ST_HDR,
    PVR_ST_TA,
    PVR_ST_DATA
  } pvr_state_e;

endpackage

/* core/pvr_mem_if.sv */
// Link between the portal logic and the MMD register store
`timescale 1ns/1ps
interface pvr_mem_if;
  logic we;
  logic [pvr_pkg::PVR_MEM_AW-1:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;

  modport ctl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface

/* core/pvr_mmd_mem.sv */
// Storage for the implemented subset of indirect MMD registers
`timescale 1ns/1ps
module pvr_mmd_mem (
  input wire logic ref_clk,
  pvr_mem_if.mem bus
);
  import pvr_pkg::*;

  logic [15:0] mem_q [PVR_MEM_DEPTH];
  logic [15:0] rdata_q;

  // Write port; contents survive the transceiver soft reset
  always_ff @(posedge ref_clk) begin
    if (bus.we) begin
      mem_q[bus.addr] <= bus.wdata;
    end
  end

  // Registered read of the current address, refreshed every cycle
  always_ff @(posedge ref_clk) begin
    rdata_q <= mem_q[bus.addr];
  end

  assign bus.rdata = rdata_q;
endmodule // pvr_mmd_mem

/* tb/pvr_top_monitor.sv */
// Port checker for the vendor register bank and MMD portal
`timescale 1ns/1ps
module pvr_top_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic mdc,
  input wire logic mdio_o,
  input wire logic mdio_oe,
  input wire logic spd_active,
  input wire logic irq_active,
  input wire logic auto_xover_en,
  input wire logic mdi_straight,
  input wire logic int_clk_gate,
  input wire logic pll_off,
  input wire logic io_test_en,
  input wire logic io_test_high,
  input wire logic ext_loopback,
  input wire logic irq_out,
  input wire logic jabber_en,
  input wire logic sqe_test_en,
  input wire logic xcvr_soft_reset
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [8:0] oe_cnt_q;

  // Length of the current read drive window
  always_ff @(posedge ref_clk) begin
    if (rst || !mdio_oe)
      oe_cnt_q <= 9'h000;
    else
      oe_cnt_q <= oe_cnt_q + 9'h001;
  end

  // Soft reset raised by a write of one
  sequence s_swrst_set;
    $rose(xcvr_soft_reset);
  endsequence

  // Output relations
  a_gate_in_spd:
    assert property (int_clk_gate |-> $past(spd_active))
    else $error("clocks gated outside power-down");
  a_pll_in_spd:
    assert property (pll_off |-> $past(spd_active))
    else $error("pll off outside power-down");
  a_straight_forced:
    assert property (mdi_straight |-> !auto_xover_en)
    else $error("forced pairs while auto crossover on");
  a_level_in_test:
    assert property (io_test_high |-> io_test_en)
    else $error("test level without test mode");
  a_irq_follows:
    assert property ((irq_active != $past(irq_active)) |=>
      (irq_out != $past(irq_out)))
    else $error("interrupt output did not follow request");
  a_ta_drives_low:
    assert property ($rose(mdio_oe) |-> !mdio_o)
    else $error("turnaround bit not low");
  a_drive_bounded:
    assert property (oe_cnt_q < 9'h168)
    else $error("data line driven too long");
  a_lpbk_on_frame:
    assert property ($changed(ext_loopback) |-> $past(mdc, 3))
    else $error("loopback changed outside a write");
  a_swrst_holds:
    assert property (s_swrst_set |-> xcvr_soft_reset [*8])
    else $error("soft reset dropped before a read");
  a_reset_values:
    assert property ($fell(rst) |-> jabber_en && sqe_test_en && auto_xover_en)
    else $error("wrong output after reset");
endmodule // pvr_top_monitor

bind pvr_top pvr_top_monitor u_pvr_top_monitor (
  .ref_clk, .rst, .mdc, .mdio_o, .mdio_oe, .spd_active, .irq_active,
  .auto_xover_en, .mdi_straight, .int_clk_gate, .pll_off, .io_test_en,
  .io_test_high, .ext_loopback, .irq_out, .jabber_en, .sqe_test_en,
  .xcvr_soft_reset
);

/* tb/pvr_smi_host.sv */
// Station management controller model on MDC and MDIO
`timescale 1ns/1ps
module pvr_smi_host (
  output logic mdc,
  output logic mdio_i,
  input wire logic mdio_o,
  input wire logic mdio_oe
);
  logic drv_en;
  logic drv_val;

  // Pulled-up line: design, host, or high when released
  assign mdio_i = mdio_oe ? mdio_o : (drv_en ? drv_val : 1'b1);

  // Clock stands low between frames
  initial begin
    mdc = 1'b0;
    drv_en = 1'b0;
    drv_val = 1'b1;
  end

  // One MDC period of 160 ns, line sampled at the rising edge
  task automatic clk_bit(output logic s);
    #80 s = mdio_i;
    mdc = 1'b1;
    #80 mdc = 1'b0;
  endtask

  // Whole frame with its own preamble; read releases from turnaround
  task automatic frame(input logic [1:0] op, input logic [4:0] phy,
      input logic [4:0] regad, input logic [15:0] wd,
      output logic [15:0] rd);
    logic [63:0] f;
    logic s;
    f = {32'hFFFFFFFF, 2'b01, op, phy, regad, 2'b10, wd};
    drv_en = 1'b1;
    for (int i = 63; i >= 0; i--) begin
      if (op == 2'b10 && i < 18)
        drv_en = 1'b0;
      drv_val = f[i];
      clk_bit(s);
      if (i < 16)
        rd[i] = s;
    end
    drv_en = 1'b0;
    #160;
  endtask
endmodule // pvr_smi_host

/* tb/tb.sv */
// Self-checking bench for the vendor register bank and MMD portal
`timescale 1ns/1ps
module tb;
  import pvr_pkg::*;
  localparam logic [4:0] PHY = 5'h05;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] phy_addr = PHY;
  logic spd_active = 1'b0, irq_active = 1'b0, link_check_fail = 1'b0;
  logic speed_1000 = 1'b0, speed_100 = 1'b0, speed_10 = 1'b0;
  logic duplex_full = 1'b0, gig_master = 1'b0;
  logic mdc, mdio_i, mdio_o, mdio_oe, auto_xover_en, mdi_straight;
  logic int_clk_gate, pll_off, io_test_en, io_test_high, ext_loopback;
  logic irq_out, jabber_en, sqe_test_en, xcvr_soft_reset;
  logic [15:0] rv;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;

  // Clock of 8 ns
  always #4 ref_clk = ~ref_clk;

  pvr_top u_pvr_top (
    .ref_clk, .rst, .mdc, .mdio_i, .mdio_o, .mdio_oe, .phy_addr,
    .spd_active, .irq_active, .link_check_fail, .speed_1000, .speed_100,
    .speed_10, .duplex_full, .gig_master, .auto_xover_en, .mdi_straight,
    .int_clk_gate, .pll_off, .io_test_en, .io_test_high, .ext_loopback,
    .irq_out, .jabber_en, .sqe_test_en, .xcvr_soft_reset
  );

  pvr_smi_host u_pvr_smi_host (.mdc, .mdio_i, .mdio_o, .mdio_oe);

  // Counts and verdict
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 95000) begin
      error_cnt++;
      stop_test();
    end
  end

  // Comparison helpers
  task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cb(input string what, input logic seen, input logic exp);
    check(what, {15'h0000, seen}, {15'h0000, exp});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Management frame accesses
  task automatic wr(input logic [4:0] r, input logic [15:0] d);
    u_pvr_smi_host.frame(PVR_OP_WRITE, PHY, r, d, rv);
  endtask
  task automatic rd(input logic [4:0] r, input logic [15:0] e);
    u_pvr_smi_host.frame(PVR_OP_READ, PHY, r, 16'h0000, rv);
    check($sformatf("reg %h", r), rv, e);
  endtask
  task automatic mmd(input logic [15:0] fn, input logic [15:0] a);
    wr(PVR_REG_MMD_CTL, fn & 16'h001F);
    wr(PVR_REG_MMD_DATA, a);
    wr(PVR_REG_MMD_CTL, fn);
  endtask

  // Main sequence
  initial begin
    tick(10);
    rst = 1'b0;
    tick(4);
    cb("auto xover", auto_xover_en, 1'b1);
    cb("irq out", irq_out, 1'b1);
    rd(PVR_REG_XOVER, 16'h0000);
    rd(PVR_REG_CTLSTAT, 16'h0300);
    $display("test reset done");
    wr(PVR_REG_XOVER, 16'hFFFF);
    rd(PVR_REG_XOVER, 16'h00C0);
    cb("auto xover", auto_xover_en, 1'b0);
    cb("straight", mdi_straight, 1'b1);
    wr(PVR_REG_XOVER, 16'h0040);
    cb("straight", mdi_straight, 1'b0);
    wr(PVR_REG_XOVER, 16'h0080);
    cb("auto xover", auto_xover_en, 1'b1);
    cb("straight", mdi_straight, 1'b0);
    $display("test crossover done");
    wr(PVR_REG_SPD, 16'hFFFF);
    rd(PVR_REG_SPD, 16'h0CC0);
    cb("io test", io_test_en, 1'b1);
    cb("io level", io_test_high, 1'b1);
    cb("pll off", pll_off, 1'b0);
    spd_active = 1'b1;
    tick(3);
    cb("clk gate", int_clk_gate, 1'b0);
    cb("pll off", pll_off, 1'b1);
    wr(PVR_REG_SPD, 16'h0080);
    cb("clk gate", int_clk_gate, 1'b1);
    cb("pll off", pll_off, 1'b0);
    cb("io level", io_test_high, 1'b0);
    spd_active = 1'b0;
    $display("test power-down done");
    u_pvr_smi_host.frame(PVR_OP_WRITE, 5'h06, PVR_REG_LPBK, 16'h0008, rv);
    cb("loopback", ext_loopback, 1'b0);
    wr(PVR_REG_LPBK, 16'hFFFF);
    rd(PVR_REG_LPBK, 16'h0008);
    cb("loopback", ext_loopback, 1'b1);
    wr(PVR_REG_LPBK, 16'h0000);
    cb("loopback", ext_loopback, 1'b0);
    $display("test loopback done");
    duplex_full = 1'b1;
    gig_master = 1'b1;
    for (int k = 0; k < 3; k++) begin
      {speed_1000, speed_100, speed_10} = 3'h1 << k;
      rd(PVR_REG_CTLSTAT, 16'h030C | (16'h0010 << k));
    end
    {speed_1000, speed_100, speed_10} = 3'h0;
    wr(PVR_REG_CTLSTAT, 16'hFCFE);
    cb("soft reset", xcvr_soft_reset, 1'b1);
    cb("jabber", jabber_en, 1'b0);
    cb("sqe", sqe_test_en, 1'b0);
    cb("irq out", irq_out, 1'b0);
    irq_active = 1'b1;
    tick(3);
    cb("irq out", irq_out, 1'b1);
    rd(PVR_REG_CTLSTAT, 16'h400E);
    cb("soft reset", xcvr_soft_reset, 1'b0);
    rd(PVR_REG_CTLSTAT, 16'h400C);
    wr(PVR_REG_CTLSTAT, 16'h0000);
    cb("irq out", irq_out, 1'b0);
    cb("soft reset", xcvr_soft_reset, 1'b0);
    link_check_fail = 1'b1;
    tick(1);
    link_check_fail = 1'b0;
    rd(PVR_REG_CTLSTAT, 16'h000D);
    rd(PVR_REG_CTLSTAT, 16'h000C);
    $display("test control done");
    rst = 1'b1;
    tick(3);
    rst = 1'b0;
    tick(4);
    cb("jabber", jabber_en, 1'b1);
    cb("sqe", sqe_test_en, 1'b1);
    cb("irq out", irq_out, 1'b0);
    rd(PVR_REG_CTLSTAT, 16'h030C);
    $display("test mid-run reset done");
    mmd(16'h0002, 16'h0003);
    rd(PVR_REG_MMD_DATA, 16'h0003);
    wr(PVR_REG_MMD_CTL, 16'h4002);
    wr(PVR_REG_MMD_DATA, 16'h1234);
    rd(PVR_REG_MMD_DATA, 16'h1234);
    rd(PVR_REG_MMD_DATA, 16'h1234);
    rd(PVR_REG_MMD_CTL, 16'h4002);
    mmd(16'h8002, 16'h0005);
    for (int k = 0; k < 3; k++)
      wr(PVR_REG_MMD_DATA, 16'h00A0 + 16'(k));
    wr(PVR_REG_MMD_CTL, 16'h0002);
    rd(PVR_REG_MMD_DATA, 16'h0008);
    mmd(16'h8002, 16'h0005);
    for (int k = 0; k < 3; k++)
      rd(PVR_REG_MMD_DATA, 16'h00A0 + 16'(k));
    wr(PVR_REG_MMD_CTL, 16'h0002);
    rd(PVR_REG_MMD_DATA, 16'h0008);
    mmd(16'hC002, 16'h0009);
    wr(PVR_REG_MMD_DATA, 16'h00D4);
    wr(PVR_REG_MMD_DATA, 16'h00E5);
    wr(PVR_REG_MMD_CTL, 16'h0002);
    rd(PVR_REG_MMD_DATA, 16'h000B);
    mmd(16'hC002, 16'h0009);
    rd(PVR_REG_MMD_DATA, 16'h00D4);
    rd(PVR_REG_MMD_DATA, 16'h00D4);
    mmd(16'h4010, 16'h0003);
    wr(PVR_REG_MMD_DATA, 16'hFFFF);
    rd(PVR_REG_MMD_DATA, 16'h0000);
    rd(PVR_REG_MMD_CTL, 16'h4010);
    rd(5'h19, 16'h0000);
    $display("test portal done");
    stop_test();
  end
endmodule // tb
